// *** core/insn_subset_map.vh ***
`ifndef INSN_SUBSET_MAP_VH
`define INSN_SUBSET_MAP_VH

// =====================================================
// operation select codes
`define OP_NONE 3'h0
`define OP_DECIMAL_ADJUST 3'h1
`define OP_DECREMENT_SKIP 3'h2
`define OP_INTERRUPT_DISABLE 3'h3
`define OP_DIRECT_JUMP 3'h4

// =====================================================
// field positions and widths
`define PC_WIDTH 11
`define JUMP_IMM_WIDTH 9
`define HIGH_BUF_JUMP_MSB 2
`define HIGH_BUF_JUMP_LSB 1
`define REG_ADDR_WIDTH 7
`define DEST_ACC 1'h0
`define DEST_REG 1'h1

// =====================================================
// reset values
`define RESET_PC 11'h000
`define RESET_ACC 8'h00
`define RESET_CARRY 1'h0
`define RESET_GIE 1'h0

// =====================================================
// decimal adjust constants
`define BCD_NIBBLE_MAX 4'h9
`define BCD_BYTE_MAX 9'h099
`define BCD_LOW_FIX 9'h006
`define BCD_HIGH_FIX 9'h060

`endif

// *** core/insn_subset_core.v ***
// Contract
// - decimal adjust turns accumulator sum into packed decimal, updates only carry
// - decrement-skip writes register minus one to accumulator (d=0) or register (d=1)
// - zero decrement result discards prefetched instruction, runs a no-op, two cycles
// - interrupt disable clears the global enable bit in one cycle, no flags
// - direct jump loads immediate into pc[8:0], buffer bits 2:1 into pc[10:9]
// - direct jump is unconditional, two cycles, status flags untouched
`timescale 1ns/1ps
`default_nettype none
`include "insn_subset_map.vh"

module insn_subset_core
#(
  parameter DATA_WIDTH = 8
)
(
  input wire clk,
  input wire reset,
  input wire issueValid,
  input wire [2:0] opSelect,
  input wire [`REG_ADDR_WIDTH-1:0] regAddr,
  input wire destBit,
  input wire [`JUMP_IMM_WIDTH-1:0] jumpImmediate,
  input wire [DATA_WIDTH-1:0] regReadData,
  input wire [2:0] programCounterHighBuffer,
  input wire halfCarry,
  input wire accLoad,
  input wire [DATA_WIDTH-1:0] accLoadValue,
  input wire carryLoadValue,
  input wire interruptEnableSet,
  output reg [DATA_WIDTH-1:0] acc,
  output reg carry,
  output reg globalInterruptEnableBit,
  output reg [`PC_WIDTH-1:0] programCounter,
  output reg regWriteEnable,
  output reg [`REG_ADDR_WIDTH-1:0] regWriteAddr,
  output reg [DATA_WIDTH-1:0] regWriteData,
  output wire flushPrefetch,
  output wire executing
);

  // =====================================================
  // squash state: the slot after a skip or jump runs as a no-op
  reg squash;
  wire live;
  wire [DATA_WIDTH-1:0] decremented;
  wire decZero;
  wire doSkip;
  wire doJump;

  assign live = issueValid && !squash;
  assign executing = live;
  assign decremented = regReadData - {{(DATA_WIDTH-1){1'b0}}, 1'b1};
  assign decZero = (decremented == {DATA_WIDTH{1'b0}});
  assign doSkip = live && (opSelect == `OP_DECREMENT_SKIP) && decZero;
  assign doJump = live && (opSelect == `OP_DIRECT_JUMP);

  // =====================================================
  // live decode of the remaining operations
  wire doAdjust;
  wire doDecrement;
  wire doDisable;
  wire decToAcc;
  wire decToReg;

  assign doAdjust = live && (opSelect == `OP_DECIMAL_ADJUST);
  assign doDecrement = live && (opSelect == `OP_DECREMENT_SKIP);
  assign doDisable = live && (opSelect == `OP_INTERRUPT_DISABLE);
  assign decToAcc = doDecrement && (destBit == `DEST_ACC);
  assign decToReg = doDecrement && (destBit == `DEST_REG);
  // combinational so the fetch stage drops its word in the same cycle
  assign flushPrefetch = doSkip || doJump;

  // =====================================================
  // decimal adjust datapath
  reg [8:0] adjLow;
  reg [8:0] adjFull;
  reg adjCarry;
  always @*
  begin
    adjLow = {1'b0, acc[7:0]};
    adjCarry = carry;
    if (halfCarry || (acc[3:0] > `BCD_NIBBLE_MAX))
    begin
      adjLow = adjLow + `BCD_LOW_FIX;
    end
    adjFull = adjLow;
    // high correction judged on the raw sum, as a decimal add would carry
    if (carry || ({1'b0, acc[7:0]} > `BCD_BYTE_MAX) || adjLow[8])
    begin
      adjFull = adjLow + `BCD_HIGH_FIX;
      adjCarry = 1'b1;
    end
  end

  // =====================================================
  // squash flag
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      squash <= 1'b0;
    end
    else
    begin
      // the word after a skip or jump is stale, so its slot is a no-op
      squash <= flushPrefetch;
    end
  end

  // =====================================================
  // program counter
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      programCounter <= `RESET_PC;
    end
    else
    begin
      if (doJump)
      begin
        programCounter <= {programCounterHighBuffer[`HIGH_BUF_JUMP_MSB:`HIGH_BUF_JUMP_LSB],
          jumpImmediate};
      end
      else if (issueValid)
      begin
        // a squashed slot still advances pc; the fetcher drops valid to hold it
        programCounter <= programCounter + 11'h001;
      end
    end
  end

  // =====================================================
  // accumulator and carry
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      acc <= `RESET_ACC;
      carry <= `RESET_CARRY;
    end
    else
    begin
      if (accLoad)
      begin
        acc <= accLoadValue;
        carry <= carryLoadValue;
      end
      // an adjust wins over a load in the same cycle; a decrement to acc overrides only acc, not carry
      if (doAdjust)
      begin
        acc <= adjFull[DATA_WIDTH-1:0];
        carry <= adjCarry;
      end
      else if (decToAcc)
      begin
        acc <= decremented;
      end
    end
  end

  // =====================================================
  // global interrupt enable
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      globalInterruptEnableBit <= `RESET_GIE;
    end
    else
    begin
      // disable wins over a simultaneous enable request
      if (doDisable)
      begin
        globalInterruptEnableBit <= 1'b0;
      end
      else if (interruptEnableSet)
      begin
        globalInterruptEnableBit <= 1'b1;
      end
    end
  end

  // =====================================================
  // register file write port
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      regWriteEnable <= 1'b0;
      regWriteAddr <= {`REG_ADDR_WIDTH{1'b0}};
      regWriteData <= {DATA_WIDTH{1'b0}};
    end
    else
    begin
      // one-cycle pulse; address and data hold until the next write
      regWriteEnable <= decToReg;
      if (decToReg)
      begin
        regWriteAddr <= regAddr;
        regWriteData <= decremented;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/insn_subset_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module insn_subset_checker(
  input wire logic clk, reset, destBit, carry, globalInterruptEnableBit,
  input wire logic regWriteEnable, flushPrefetch, executing,
  input wire logic [2:0] opSelect, programCounterHighBuffer,
  input wire logic [8:0] jumpImmediate,
  input wire logic [7:0] regReadData, acc, regWriteData,
  input wire logic [10:0] programCounter
);
  // ==========
  // decoded ops
  wire dec = executing && opSelect == 3'h2;
  wire jmp = executing && opSelect == 3'h4;
  wire dis = executing && opSelect == 3'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_da; dec && !destBit |=> acc == $past(regReadData) - 8'h01; endproperty
  a_da: assert property (p_da) else $error("dec to acc");
  property p_dr; dec && destBit |=> regWriteEnable && regWriteData == $past(regReadData) - 8'h01;
  endproperty
  a_dr: assert property (p_dr) else $error("dec to reg");
  property p_sk; dec |-> flushPrefetch == (regReadData == 8'h01); endproperty
  a_sk: assert property (p_sk) else $error("skip flush");
  property p_sq; flushPrefetch |=> !executing; endproperty
  a_sq: assert property (p_sq) else $error("slot not squashed");
  property p_di; dis |=> !globalInterruptEnableBit && $stable(carry); endproperty
  a_di: assert property (p_di) else $error("disable");
  property p_jp; jmp |=> programCounter ==
    {$past(programCounterHighBuffer[2:1]), $past(jumpImmediate)}; endproperty
  a_jp: assert property (p_jp) else $error("jump target");
  property p_jf; jmp |-> flushPrefetch; endproperty
  a_jf: assert property (p_jf) else $error("jump flush");
  property p_js; jmp |=> $stable(carry) && $stable(acc); endproperty
  a_js: assert property (p_js) else $error("jump flags");
endmodule
bind insn_subset_core insn_subset_checker i_insn_subset_checker(.clk, .reset, .destBit, .carry,
  .globalInterruptEnableBit, .regWriteEnable, .flushPrefetch, .executing, .opSelect,
  .programCounterHighBuffer, .jumpImmediate, .regReadData, .acc, .regWriteData, .programCounter);
`default_nettype wire

// *** tb/insn_subset_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module insn_subset_core_tb_top;
  logic clk = 0, reset = 1, iv = 0, dst = 0, hc = 0, al = 0, cl = 0, ies = 0;
  logic [2:0] op = 0, hb = 3'h5;
  logic [6:0] ra = 7'h7F;
  logic [8:0] imm = 9'h1A5;
  logic [7:0] rd = 0, av = 0;
  wire [7:0] acc, wd;
  wire c, global_interrupt_enable_bit, we, fl, ex;
  wire [10:0] pc;
  wire [6:0] wa;
  int failures = 0, checks = 0, cyc = 0;
  // ==========
  // sum, carry in, half carry, adjusted sum, carry out
  logic [18:0] rows [4] = '{{8'h4D, 2'b00, 8'h53, 1'b0}, {8'h9A, 2'b00, 8'h00, 1'b1},
    {8'h12, 2'b10, 8'h72, 1'b1}, {8'h71, 2'b01, 8'h77, 1'b0}};
  insn_subset_core i_insn_subset_core(.clk(clk), .reset(reset), .issueValid(iv), .opSelect(op),
    .regAddr(ra), .destBit(dst), .jumpImmediate(imm), .regReadData(rd),
    .programCounterHighBuffer(hb), .halfCarry(hc), .accLoad(al), .accLoadValue(av),
    .carryLoadValue(cl), .interruptEnableSet(ies), .acc(acc), .carry(c),
    .globalInterruptEnableBit(global_interrupt_enable_bit), .programCounter(pc), .regWriteEnable(we),
    .regWriteAddr(wa), .regWriteData(wd), .flushPrefetch(fl), .executing(ex));
  initial forever #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 200)
    begin
      failures++;
      test_done();
    end
  end
  task chk(input string n, input logic [10:0] g, e);
    checks++;
    if (g !== e) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
  endtask
  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 0;
    #1 chk("pc", pc, 0);
    foreach (rows[i])
    begin
      @(posedge clk) {av, cl, hc} <= rows[i][18:9]; al <= 1;
      @(posedge clk) al <= 0; op <= 1; iv <= 1;
      @(posedge clk) iv <= 0;
      #1 chk("acc", acc, rows[i][8:1]);
      chk("carry", c, rows[i][0]);
    end
    $display("adjust done");
    // back to back decrements, second one skips
    @(posedge clk) op <= 2; iv <= 1; rd <= 8'h05;
    #1 chk("flush", fl, 0);
    @(posedge clk) dst <= 1; rd <= 8'h01;
    #1 chk("acc", acc, 8'h04);
    chk("flush", fl, 1);
    @(posedge clk) op <= 4;
    #1 chk("exec", ex, 0);
    chk("write", {we, wa, wd[2:0]}, {1'b1, 7'h7F, 3'h0});
    @(posedge clk) dst <= 0;
    #1 chk("flush", fl, 1);
    @(posedge clk) op <= 3; ies <= 1;
    #1 chk("pc", pc, 11'h5A5);
    chk("exec", ex, 0);
    $display("skip and jump done");
    @(posedge clk) ies <= 0;
    #1 chk("gie", global_interrupt_enable_bit, 1);
    @(posedge clk) iv <= 0;
    #1 chk("gie", global_interrupt_enable_bit, 0);
    chk("carry", c, 0);
    $display("disable done");
    test_done();
  end
endmodule
`default_nettype wire
